// file: src/rx_flag_status.sv
// Receiver flag and bus-state status register with AXI4-Lite slave
// What this block does
// - Flags clear on write-one once cause gone
// - Flag and enable writes only outside init; control writes and reads always
// - Zero writes ignored; state fields read-only
// - Init mode holds the four flags reset
// - State fields survive initialization mode
// - Wake flag on bus activity in sleep
// - Wake request follows flag and enable
// - Counter-driven bus state change sets flag
// - State fields freeze while change flag set
// - Receiver state coding from receive count
// - Receiver reads bus-off when transmitter bus-off
// - Transmitter state coding from transmit count
// - Overrun condition sets overrun flag
// - Error request from change or overrun
// - Good message to foreground sets full flag
// - Full flag blocks next foreground shift
// - Receive request follows full flag enable
// - Each flag has own enable bit
// - Sensitivity selects which changes set flag
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rxflag_regs.svh"

module rx_flag_status
  import rxflag_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Controller status from the protocol engine
  input wire logic init_acknowledge,
  input wire logic sleep_active,
  input wire logic bus_activity,
  input wire logic [8:0] rx_err_count,
  input wire logic [8:0] tx_err_count,
  input wire logic overrun_event,
  input wire logic good_msg_event,
  input wire logic fifo_not_empty,
  // Interrupt requests, foreground shift strobe and init request
  output logic wake_irq,
  output logic error_irq,
  output logic rx_irq,
  output logic fg_shift,
  output logic init_request
);

  // All checks below run on the module clock and pause in reset
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Register state
  logic [7:0] ctrl_q; // bit0 init request, bit1 wake detect enable
  logic [7:0] rx_irq_enable_reg_q;
  logic wake_flag_q;
  logic bus_state_change_flag_q;
  logic overrun_flag_q;
  logic msg_ready_flag_q;
  bus_state_t rx_bus_state_q;
  bus_state_t tx_bus_state_q;
  bus_state_t rx_live_q; // Last live state, for change detection
  bus_state_t tx_live_q;
  logic live_valid_q; // Live copies loaded after reset

  // Bus handshake state
  logic aw_hold_q;
  logic w_hold_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // Derived signals
  logic in_init;
  logic wake_detect_enable;
  logic wr_fire;
  logic wr_flags;
  logic wr_ien;
  logic wr_ctrl;
  logic wr_hit;
  logic [7:0] clr;
  bus_state_t rx_now;
  bus_state_t tx_now;
  logic rx_sig;
  logic tx_sig;
  logic csc_event;
  logic [7:0] flag_reg;

  // Init mode is the request and acknowledge both high
  assign in_init = ctrl_q[0] && init_acknowledge;
  assign wake_detect_enable = ctrl_q[1];

  // Write is performed once address and data have both arrived
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_flags = wr_fire && (aw_addr_q == `OFS_FLAG_STATUS);
  assign wr_ien = wr_fire && (aw_addr_q == `OFS_IRQ_ENABLE);
  assign wr_ctrl = wr_fire && (aw_addr_q == `OFS_CONTROL);
  assign wr_hit = wr_flags || wr_ien || wr_ctrl;

  // Write-one clear mask, only outside init and with lane 0 enabled
  assign clr = (wr_flags && !in_init && w_strb_q[0]) ?
               w_data_q[7:0] : 8'h00;

  // Live receiver state from the counters
  always_comb begin
    if (tx_err_count >= `LVL_BUSOFF) begin
      rx_now = ST_BUSOFF;
    end else if (rx_err_count >= `LVL_ERR) begin
      rx_now = ST_ERR;
    end else if (rx_err_count >= `LVL_WARN) begin
      rx_now = ST_WARN;
    end else begin
      rx_now = ST_OK;
    end
  end

  // Live transmitter state from the counters
  always_comb begin
    if (tx_err_count >= `LVL_BUSOFF) begin
      tx_now = ST_BUSOFF;
    end else if (tx_err_count >= `LVL_ERR) begin
      tx_now = ST_ERR;
    end else if (tx_err_count >= `LVL_WARN) begin
      tx_now = ST_WARN;
    end else begin
      tx_now = ST_OK;
    end
  end

  // Sensitivity filter: 01 bus-off edges, 10 error or bus-off, 11 all
  function automatic logic sens_hit(input logic [1:0] sel,
                                    input bus_state_t old_s,
                                    input bus_state_t new_s);
    logic hit;
    hit = 1'b0;
    if (old_s != new_s) begin
      case (sel)
        2'h1: hit = (old_s == ST_BUSOFF) || (new_s == ST_BUSOFF);
        2'h2: hit = (old_s[1] != new_s[1]) || (old_s == ST_BUSOFF) ||
                    (new_s == ST_BUSOFF);
        2'h3: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
    return hit;
  endfunction : sens_hit

  assign rx_sig = sens_hit(rx_irq_enable_reg_q[5:4], rx_live_q, rx_now);
  assign tx_sig = sens_hit(rx_irq_enable_reg_q[3:2], tx_live_q, tx_now);
  assign csc_event = live_valid_q && (rx_sig || tx_sig);

  // Live state tracker, independent of init mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_live_q <= ST_OK;
      tx_live_q <= ST_OK;
      live_valid_q <= 1'b0;
    end else begin
      rx_live_q <= rx_now;
      tx_live_q <= tx_now;
      live_valid_q <= 1'b1;
    end
  end

  // Visible state fields, frozen while change flag pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_bus_state_q <= ST_OK;
      tx_bus_state_q <= ST_OK;
    end else if (!bus_state_change_flag_q) begin
      rx_bus_state_q <= rx_now;
      tx_bus_state_q <= tx_now;
    end
  end

  // Wake flag: set wins over clear; clear only once activity gone
  always_ff @(posedge aclk) begin
    if (!aresetn || in_init) begin
      wake_flag_q <= 1'b0;
    end else if (sleep_active && bus_activity && wake_detect_enable) begin
      wake_flag_q <= 1'b1;
    end else if (clr[`BIT_WAKE] && !bus_activity) begin
      wake_flag_q <= 1'b0;
    end
  end

  // Change flag
  always_ff @(posedge aclk) begin
    if (!aresetn || in_init) begin
      bus_state_change_flag_q <= 1'b0;
    end else if (csc_event) begin
      bus_state_change_flag_q <= 1'b1;
    end else if (clr[`BIT_CSC]) begin
      bus_state_change_flag_q <= 1'b0;
    end
  end

  // Overrun flag
  always_ff @(posedge aclk) begin
    if (!aresetn || in_init) begin
      overrun_flag_q <= 1'b0;
    end else if (overrun_event) begin
      overrun_flag_q <= 1'b1;
    end else if (clr[`BIT_OVR]) begin
      overrun_flag_q <= 1'b0;
    end
  end

  // Foreground shift: only while full flag is clear and FIFO holds data or a good message arrives
  always_ff @(posedge aclk) begin
    if (!aresetn || in_init) begin
      fg_shift <= 1'b0;
    end else begin
      fg_shift <= !msg_ready_flag_q && !fg_shift &&
                  (fifo_not_empty || good_msg_event) &&
                  !(clr[`BIT_RXF]);
    end
  end

  // Full flag set by a shift of a good message; reload after clear
  always_ff @(posedge aclk) begin
    if (!aresetn || in_init) begin
      msg_ready_flag_q <= 1'b0;
    end else if (fg_shift) begin
      msg_ready_flag_q <= 1'b1;
    end else if (clr[`BIT_RXF]) begin
      msg_ready_flag_q <= 1'b0;
    end
  end

  // Enable register, held reset in init mode, per-flag enables
  always_ff @(posedge aclk) begin
    if (!aresetn || in_init) begin
      rx_irq_enable_reg_q <= `RST_IRQ_ENABLE;
    end else if (wr_ien && w_strb_q[0]) begin
      rx_irq_enable_reg_q <= w_data_q[7:0];
    end
  end

  // Control register: init request and wake detect enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `RST_CONTROL;
    end else if (wr_ctrl && w_strb_q[0]) begin
      ctrl_q <= {6'h00, w_data_q[1:0]};
    end
  end

  // Interrupt requests registered from flags and enables; init request registered from control bit 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_irq <= 1'b0;
      error_irq <= 1'b0;
      rx_irq <= 1'b0;
      init_request <= 1'b0;
    end else begin
      wake_irq <= wake_flag_q && rx_irq_enable_reg_q[`BIT_WAKE];
      error_irq <= (bus_state_change_flag_q &&
                    rx_irq_enable_reg_q[`BIT_CSC]) ||
                   (overrun_flag_q && rx_irq_enable_reg_q[`BIT_OVR]);
      rx_irq <= msg_ready_flag_q && rx_irq_enable_reg_q[`BIT_RXF];
      init_request <= ctrl_q[0];
    end
  end

  assign flag_reg = {wake_flag_q, bus_state_change_flag_q, rx_bus_state_q,
                     tx_bus_state_q, overrun_flag_q, msg_ready_flag_q};

  // Write channel: capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
      end
    end
  end

  // Read channel: one-cycle accept, data next cycle; readable anytime
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        if (s_axi_araddr == `OFS_FLAG_STATUS) begin
          s_axi_rdata <= {24'h000000, flag_reg};
        end else if (s_axi_araddr == `OFS_IRQ_ENABLE) begin
          s_axi_rdata <= {24'h000000, rx_irq_enable_reg_q};
        end else if (s_axi_araddr == `OFS_CONTROL) begin
          s_axi_rdata <= {23'h0, init_acknowledge, ctrl_q};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  chk_state_freeze: assert property (
    bus_state_change_flag_q |=>
      $stable(rx_bus_state_q) && $stable(tx_bus_state_q))
    else $error("state field moved while change flag set");
  chk_rx_busoff: assert property (
    (!bus_state_change_flag_q && tx_err_count >= `LVL_BUSOFF)
    |=> rx_bus_state_q == ST_BUSOFF)
    else $error("receiver state not bus-off");
  chk_tx_coding: assert property (
    (!bus_state_change_flag_q && tx_err_count < `LVL_WARN)
    |=> tx_bus_state_q == ST_OK)
    else $error("transmitter state coding wrong");
  chk_rx_coding: assert property (
    (!bus_state_change_flag_q && tx_err_count < `LVL_BUSOFF &&
     rx_err_count >= `LVL_WARN && rx_err_count < `LVL_ERR)
    |=> rx_bus_state_q == ST_WARN)
    else $error("receiver state coding wrong");
  chk_init_hold: assert property (
    in_init |=> !wake_flag_q && !bus_state_change_flag_q &&
      !msg_ready_flag_q && !overrun_flag_q)
    else $error("flags not held reset in init");
  chk_zero_write: assert property (
    (overrun_flag_q && !in_init && !clr[`BIT_OVR]) |=> overrun_flag_q)
    else $error("overrun flag lost without write one");
  chk_overrun_set: assert property (
    (overrun_event && !in_init) |=> overrun_flag_q)
    else $error("overrun not flagged");
  chk_full_block: assert property (
    msg_ready_flag_q |=> !fg_shift)
    else $error("shift while full flag set");
  chk_rx_request: assert property (
    (msg_ready_flag_q && rx_irq_enable_reg_q[`BIT_RXF]) |=> rx_irq)
    else $error("receive request missing");
  chk_err_request: assert property (
    (overrun_flag_q && rx_irq_enable_reg_q[`BIT_OVR]) |=> error_irq)
    else $error("error request missing");
  chk_wake_set: assert property (
    (sleep_active && bus_activity && wake_detect_enable && !in_init)
    |=> wake_flag_q ##1
      wake_irq == $past(rx_irq_enable_reg_q[`BIT_WAKE]))
    else $error("wake flag or request wrong");

endmodule : rx_flag_status

`default_nettype wire

// file: pkg/rxflag_regs.svh
// Register offsets, field positions and reset values of the receiver flag block
`ifndef RXFLAG_REGS_SVH
`define RXFLAG_REGS_SVH

`define OFS_FLAG_STATUS 4'h0
`define OFS_IRQ_ENABLE 4'h4
`define OFS_CONTROL 4'h8
`define BIT_WAKE 7
`define BIT_CSC 6
`define BIT_OVR 1
`define BIT_RXF 0
`define RST_IRQ_ENABLE 8'h00
`define RST_CONTROL 8'h00
`define LVL_WARN 9'h060
`define LVL_ERR 9'h080
`define LVL_BUSOFF 9'h100
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: pkg/rxflag_pkg.sv
// Types shared by the receiver flag block
`default_nettype none

package rxflag_pkg;
  // Bus state coding of both state fields
  typedef enum logic [1:0] {
    ST_OK = 2'h0,
    ST_WARN = 2'h1,
    ST_ERR = 2'h2,
    ST_BUSOFF = 2'h3
  } bus_state_t;
endpackage : rxflag_pkg

`default_nettype wire

// file: sim/engine_model.sv
// Engine side model: init handshake and receive FIFO occupancy
`timescale 1ns/1ps
`default_nettype none

module engine_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic init_request,
  input wire logic fg_shift,
  input wire logic push,
  output logic init_acknowledge,
  output logic good_msg_event,
  output logic fifo_not_empty
);
  logic [3:0] count_q; // Entries waiting behind the foreground

  // Acknowledge follows the request one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_acknowledge <= 1'b0;
    end else begin
      init_acknowledge <= init_request;
    end
  end

  // Messages in from the bus, shifts out to the foreground
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= 4'h0;
    end else begin
      count_q <= count_q + {3'h0, push} - {3'h0, fg_shift};
    end
  end

  // Only correctly received frames are announced
  assign good_msg_event = push;
  assign fifo_not_empty = (count_q != 4'h0);
endmodule : engine_model

`default_nettype wire

// file: sim/tb_can_receiver_flag_status.sv
// Self-checking bench for the receiver flag and bus-state register
`timescale 1ns/1ps
`default_nettype none

module tb_can_receiver_flag_status;
  import rxflag_pkg::*;
  logic aclk = 1'b0; // Module clock, 25 ns period
  logic aresetn = 1'b0; // Synchronous reset, active low
  logic [3:0] awaddr = 4'h0, araddr = 4'h0; // Bus addresses
  logic [31:0] wdata = 32'h0, rdata; // Bus data
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0; // Write handshake
  logic arvalid = 1'b0, rready = 1'b0; // Read handshake
  logic awready, wready, bvalid, arready, rvalid; // Slave answers
  logic [1:0] bresp, rresp, resp; // Response codes, last one kept
  logic sleep_active = 1'b0, bus_activity = 1'b0; // Sleep and bus
  logic overrun_event = 1'b0, push = 1'b0; // Receive events
  logic [8:0] rx_cnt = 9'h0, tx_cnt = 9'h0; // Error counters
  logic init_acknowledge, good_msg_event, fifo_not_empty; // From model
  logic wake_irq, error_irq, rx_irq, fg_shift, init_request; // Outputs
  logic f; // Expected change flag in the sweep
  int err_count = 0; // Mismatches
  int n_tests = 0; // Comparisons
  int n_shift = 0; // Foreground shifts seen

  // Free running clock
  always #12.5 aclk = ~aclk;

  // Count foreground shift pulses
  always @(posedge aclk) begin
    if (fg_shift === 1'b1) n_shift <= n_shift + 1;
  end

  rx_flag_status rx_flag_status_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .init_acknowledge(init_acknowledge),
    .sleep_active(sleep_active), .bus_activity(bus_activity),
    .rx_err_count(rx_cnt), .tx_err_count(tx_cnt),
    .overrun_event(overrun_event), .good_msg_event(good_msg_event),
    .fifo_not_empty(fifo_not_empty), .wake_irq(wake_irq),
    .error_irq(error_irq), .rx_irq(rx_irq), .fg_shift(fg_shift),
    .init_request(init_request)
  );

  engine_model engine_model_i (
    .aclk(aclk), .aresetn(aresetn), .init_request(init_request),
    .fg_shift(fg_shift), .push(push),
    .init_acknowledge(init_acknowledge),
    .good_msg_event(good_msg_event), .fifo_not_empty(fifo_not_empty)
  );

  // Compare one value, count it and report a mismatch
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_tests++;
      if (got !== exp) begin
        err_count++;
        $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask : check

  // Let a number of clock edges pass
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle

  // Write one register word; address and data offered together
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int n;
    begin
      n = 0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(posedge aclk);
        n++;
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 40);
      resp = bresp;
      if (n >= 40) err_count++;
      bready <= 1'b0;
      @(posedge aclk);
    end
  endtask : wr

  // Read one register word and compare it
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    int n;
    begin
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(posedge aclk);
        n++;
        if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 40);
      resp = rresp;
      if (n >= 40) err_count++;
      check(rdata, e);
      rready <= 1'b0;
      @(posedge aclk);
    end
  endtask : rd

  // Print the counts and the verdict, then stop
  task automatic complete_run;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask : complete_run

  // Watchdog against a hung handshake
  initial begin
    #500000;
    err_count++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    // Every receiver sensitivity against a warning and an error step
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 2; k++) begin
        f = (s == 3) || (s == 2 && k == 1);
        wr(4'h4, {2'b11, 2'(s), 4'h3});
        rx_cnt <= (k == 1) ? 9'h080 : 9'h060;
        idle(3);
        rd(4'h0, {25'h0, f, (k == 1) ? 2'b10 : 2'b01, 4'h0});
        check(error_irq, {31'h0, f});
        wr(4'h8, 8'h01);
        rx_cnt <= 9'h000;
        idle(3);
        wr(4'h4, 8'hff);
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h101);
        wr(4'h8, 8'h00);
      end
    end
    $display("test sensitivity done");
    // Transmitter sensitivity 01 reacts to bus-off edges only
    wr(4'h4, 8'h04);
    tx_cnt <= 9'h080;
    idle(3);
    rd(4'h0, 32'h08);
    tx_cnt <= 9'h100;
    idle(3);
    rd(4'h0, 32'h7c);
    tx_cnt <= 9'h000;
    idle(3);
    wr(4'h0, 8'h40);
    rd(4'h0, 32'h00);
    // Transmitter climb to bus-off with frozen fields
    wr(4'h4, 8'hff);
    tx_cnt <= 9'h080;
    idle(3);
    rd(4'h0, 32'h48);
    tx_cnt <= 9'h100;
    idle(3);
    rd(4'h0, 32'h48);
    wr(4'h0, 8'h00);
    rd(4'h0, 32'h48);
    wr(4'h0, 8'h3c);
    rd(4'h0, 32'h48);
    tx_cnt <= 9'h080;
    idle(2);
    wr(4'h0, 8'h40);
    rd(4'h0, 32'h08);
    tx_cnt <= 9'h100;
    idle(3);
    rd(4'h0, 32'h7c);
    check(error_irq, 32'h1);
    wr(4'h0, 8'h40);
    rd(4'h0, 32'h3c);
    tx_cnt <= 9'h000;
    idle(3);
    rd(4'h0, 32'h40);
    wr(4'h0, 8'h40);
    rd(4'h0, 32'h00);
    check(error_irq, 32'h0);
    $display("test bus state done");
    // Wake-up while asleep, clear refused while activity lasts
    wr(4'h8, 8'h02);
    sleep_active <= 1'b1;
    bus_activity <= 1'b1;
    idle(3);
    rd(4'h0, 32'h80);
    check(wake_irq, 32'h1);
    wr(4'h0, 8'h80);
    rd(4'h0, 32'h80);
    bus_activity <= 1'b0;
    sleep_active <= 1'b0;
    idle(2);
    wr(4'h0, 8'h80);
    rd(4'h0, 32'h00);
    check(wake_irq, 32'h0);
    $display("test wake done");
    // Overrun pulse
    overrun_event <= 1'b1;
    @(posedge aclk);
    overrun_event <= 1'b0;
    idle(2);
    check(error_irq, 32'h1);
    rd(4'h0, 32'h02);
    wr(4'h0, 8'h02);
    rd(4'h0, 32'h00);
    $display("test overrun done");
    // Two messages: second waits until the first is released
    push <= 1'b1;
    idle(2);
    push <= 1'b0;
    idle(4);
    rd(4'h0, 32'h01);
    check(rx_irq, 32'h1);
    check(fifo_not_empty, 32'h1);
    wr(4'h0, 8'h01);
    idle(3);
    rd(4'h0, 32'h01);
    check(fifo_not_empty, 32'h0);
    wr(4'h0, 8'h01);
    rd(4'h0, 32'h00);
    check(rx_irq, 32'h0);
    check(32'(n_shift), 32'h2);
    $display("test receive done");
    // Unmapped address is refused both ways
    wr(4'hc, 8'hff);
    check(resp, 32'h2);
    rd(4'hc, 32'h0);
    check(resp, 32'h2);
    $display("test unmapped done");
    complete_run();
  end
endmodule : tb_can_receiver_flag_status

`default_nettype wire
